// ==== kwdt_consts.svh ====
// register offsets, field positions, reset values and keys of the keyed watchdog
`ifndef KWDT_CONSTS_SVH
`define KWDT_CONSTS_SVH
`define KWDT_IDX_COUNT 16'h4000
`define KWDT_IDX_PERIOD 16'h4001
`define KWDT_IDX_CTRL1 16'h4002
`define KWDT_IDX_CTRL2 16'h4003
`define KWDT_KEY_FIRST 12'h5C6
`define KWDT_KEY_SECOND 12'hA7E
`define KWDT_RST_COUNT 16'hFFFF
`define KWDT_RST_PERIOD 16'hFFFF
`define KWDT_RST_PRESC 16'hFFFF
`define KWDT_RST_MODE 1'b1
`define KWDT_RST_DIVIDE 4'hF
`define KWDT_RST_ROUTE 2'h0
`define KWDT_ROUTE_IRQ 2'h0
`define KWDT_ROUTE_NMI 2'h1
`define KWDT_ROUTE_RST 2'h2
`define KWDT_C1_ROUTE_LSB 12
`define KWDT_C1_SOFT 11
`define KWDT_C1_FREE 10
`define KWDT_C1_PSC_LSB 6
`define KWDT_C1_DIV_LSB 0
`define KWDT_C2_FLAG 15
`define KWDT_C2_ARM 14
`define KWDT_C2_MODE 12
`define KWDT_C2_KEY_LSB 0
`define KWDT_PRESET_DEFAULT 256'hFFFF_7FFF_3FFF_1FFF_0FFF_07FF_03FF_01FF_00FF_007F_003F_001F_000F_0007_0003_0001
`endif

// ==== kwdt_pkg.sv ====
// types shared by the keyed watchdog
package kwdt_pkg;
  typedef enum logic [1:0] {
    KWDT_INIT,
    KWDT_PRE,
    KWDT_ACTIVE,
    KWDT_TIMEOUT
  } kwdt_state_t;
  typedef logic [15:0] kwdt_word_t;
endpackage

// ==== kwdt_top.sv ====
// keyed watchdog timer with an ahb-lite register slave
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "kwdt_consts.svh"
module kwdt_top #(
  parameter logic [255:0] PRESET_TABLE = `KWDT_PRESET_DEFAULT
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic watchdog_irq,
  output logic wd_nmi,
  output logic wd_reset_req,
  output kwdt_pkg::kwdt_state_t wd_state
);
  import kwdt_pkg::*;

  // prescaler reload value for a mode and divide field
  function automatic kwdt_word_t presc_load(input logic mode, input logic [3:0] div);
    kwdt_word_t v;
    v = {12'h000, div};
    if (mode) begin
      v = PRESET_TABLE[{div, 4'h0} +: 16];
    end
    return v;
  endfunction

  // matches a word address against a register index
  function automatic logic idx_hit(input logic [31:0] a, input logic [15:0] idx);
    return (a[31:18] == 14'h0000) && (a[17:2] == idx);
  endfunction

  kwdt_state_t st_q, st_d;
  kwdt_word_t main_q, main_d;
  kwdt_word_t period_q;
  kwdt_word_t presc_q, presc_d;
  logic [1:0] route_q;
  logic soft_q, free_q, mode_q, flag_q, seen_q;
  logic [3:0] div_q;
  logic dp_valid_q, dp_write_q;
  logic [31:0] dp_addr_q;
  logic [31:0] hrdata_q;
  logic irq_q, nmi_q, rst_q;

  // address phase capture; the slave never inserts wait states
  wire logic ap_take = hsel & hready & htrans[1];
  wire logic wr_en = dp_valid_q & dp_write_q;
  wire logic sel_count = idx_hit(dp_addr_q, `KWDT_IDX_COUNT);
  wire logic sel_period = idx_hit(dp_addr_q, `KWDT_IDX_PERIOD);
  wire logic sel_ctrl1 = idx_hit(dp_addr_q, `KWDT_IDX_CTRL1);
  wire logic sel_ctrl2 = idx_hit(dp_addr_q, `KWDT_IDX_CTRL2);

  // configuration is open only before arming
  wire logic unlocked = (st_q == KWDT_INIT) | (st_q == KWDT_PRE);
  wire logic [11:0] key = hwdata[`KWDT_C2_KEY_LSB +: 12];
  wire logic key_wr = wr_en & sel_ctrl2;
  wire logic k_first = key == `KWDT_KEY_FIRST;
  wire logic k_second = key == `KWDT_KEY_SECOND;
  wire logic w_arm = hwdata[`KWDT_C2_ARM];
  wire logic w_mode = hwdata[`KWDT_C2_MODE];

  // key sequence decode
  wire logic go_pre = (st_q == KWDT_INIT) & key_wr & k_first;
  wire logic go_arm = (st_q == KWDT_PRE) & key_wr & k_second & w_arm;
  wire logic armed = st_q == KWDT_ACTIVE;
  wire logic svc = armed & key_wr & k_second & seen_q;
  wire logic bad_key = armed & key_wr & ~(k_first | (k_second & seen_q));
  wire logic expire = armed & (main_q == 16'h0000);
  wire logic go_to = bad_key | expire;
  wire logic tick = armed & (presc_q == 16'h0000);
  wire logic pre_ok = (st_q == KWDT_PRE) & (k_first | k_second);
  wire logic c2_wr = key_wr & ((st_q == KWDT_INIT) | pre_ok);
  wire logic load_now = go_arm | svc;
  wire logic load_mode = go_arm ? w_mode : mode_q;

  // register read mux, sampled in the address phase
  wire logic [31:0] rd_count = {16'h0000, main_q};
  wire logic [31:0] rd_period = {16'h0000, period_q};
  wire logic [31:0] rd_ctrl1 = {18'h00000, route_q, soft_q, free_q,
                                presc_q[3:0], 2'h0, div_q};
  wire logic [31:0] rd_ctrl2 = {16'h0000, flag_q, armed, 1'b0, mode_q, 12'h000};
  wire logic [31:0] rd_mux =
    idx_hit(haddr, `KWDT_IDX_COUNT) ? rd_count :
    idx_hit(haddr, `KWDT_IDX_PERIOD) ? rd_period :
    idx_hit(haddr, `KWDT_IDX_CTRL1) ? rd_ctrl1 :
    idx_hit(haddr, `KWDT_IDX_CTRL2) ? rd_ctrl2 : 32'h0000_0000;

  // state sequence; reads never reach here
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      KWDT_INIT: begin
        if (go_pre) begin
          st_d = KWDT_PRE;
        end
      end
      KWDT_PRE: begin
        if (go_arm) begin
          st_d = KWDT_ACTIVE;
        end
      end
      KWDT_ACTIVE: begin
        if (go_to) begin
          st_d = KWDT_TIMEOUT;
        end
      end
      KWDT_TIMEOUT: begin
        st_d = KWDT_TIMEOUT;
      end
    endcase
  end

  // main counter: reload on arm or service, writable while unlocked
  always_comb begin
    main_d = main_q;
    if (load_now) begin
      main_d = period_q;
    end else if (wr_en & sel_count & unlocked) begin
      main_d = hwdata[15:0];
    end else if (tick & ~expire) begin
      main_d = main_q - 16'h0001;
    end
  end

  // prescaler: counts only while armed
  always_comb begin
    presc_d = presc_q;
    if (load_now) begin
      presc_d = presc_load(load_mode, div_q);
    end else if (tick) begin
      presc_d = presc_load(mode_q, div_q);
    end else if (armed) begin
      presc_d = presc_q - 16'h0001;
    end
  end

  // bus pipeline and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_addr_q <= 32'h0000_0000;
      hrdata_q <= 32'h0000_0000;
    end else begin
      dp_valid_q <= ap_take;
      dp_write_q <= hwrite;
      dp_addr_q <= haddr;
      hrdata_q <= (ap_take & ~hwrite) ? rd_mux : hrdata_q;
    end
  end

  // counters and sequence state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= KWDT_INIT;
      main_q <= `KWDT_RST_COUNT;
      presc_q <= `KWDT_RST_PRESC;
      seen_q <= 1'b0;
    end else begin
      st_q <= st_d;
      main_q <= main_d;
      presc_q <= presc_d;
      seen_q <= armed & ~go_to & ((key_wr & k_first) | (seen_q & ~svc));
    end
  end

  // configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      period_q <= `KWDT_RST_PERIOD;
      route_q <= `KWDT_RST_ROUTE;
      soft_q <= 1'b0;
      free_q <= 1'b0;
      div_q <= `KWDT_RST_DIVIDE;
      mode_q <= `KWDT_RST_MODE;
    end else begin
      if (wr_en & sel_period & unlocked) begin
        period_q <= hwdata[15:0];
      end
      if (wr_en & sel_ctrl1 & unlocked) begin
        route_q <= hwdata[`KWDT_C1_ROUTE_LSB +: 2];
        soft_q <= hwdata[`KWDT_C1_SOFT];
        free_q <= hwdata[`KWDT_C1_FREE];
        div_q <= hwdata[`KWDT_C1_DIV_LSB +: 4];
      end
      if (c2_wr) begin
        mode_q <= w_mode;
      end
    end
  end

  // timeout flag and routed event pulses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= 1'b0;
      irq_q <= 1'b0;
      nmi_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      flag_q <= flag_q | go_to;
      irq_q <= go_to & (route_q == `KWDT_ROUTE_IRQ);
      nmi_q <= go_to & (route_q == `KWDT_ROUTE_NMI);
      rst_q <= go_to & (route_q == `KWDT_ROUTE_RST);
    end
  end

  // outputs straight from flops; hreadyout and hresp tied to constants
  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign watchdog_irq = irq_q;
  assign wd_nmi = nmi_q;
  assign wd_reset_req = rst_q;
  assign wd_state = st_q;

  // checks
  default clocking dcb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_init_holds: assert property (
    (st_q == KWDT_INIT) && !(wr_en && sel_count) |=> main_q == $past(main_q)
  ) else $error("counter moved while idle");

  a_arm_reload: assert property (
    go_arm |=> (st_q == KWDT_ACTIVE) && (main_q == $past(period_q))
      && (presc_q == presc_load($past(w_mode), $past(div_q)))
  ) else $error("arming did not reload");

  a_no_disarm: assert property (
    (st_q == KWDT_ACTIVE) && !go_to |=> st_q == KWDT_ACTIVE
  ) else $error("left active without timeout");

  a_first_key: assert property (
    (st_q == KWDT_INIT) && key_wr && k_first |=> st_q == KWDT_PRE
  ) else $error("first key not taken");

  a_mode_latch: assert property (
    go_arm |=> mode_q == $past(w_mode)
  ) else $error("mode not latched on arm");

  a_service_reload: assert property (
    svc && !expire |=> (main_q == $past(period_q)) && (st_q == KWDT_ACTIVE)
  ) else $error("service did not reload");

  a_bad_key: assert property (
    bad_key |=> (st_q == KWDT_TIMEOUT) && flag_q
  ) else $error("wrong key did not time out");

  a_flag_sets: assert property (
    (st_q == KWDT_ACTIVE) ##1 (st_q == KWDT_TIMEOUT) |-> flag_q
  ) else $error("flag missing after timeout");

  a_route_event: assert property (
    go_to && (route_q == `KWDT_ROUTE_NMI) |=> wd_nmi && !watchdog_irq ##1 !wd_nmi
  ) else $error("nmi route wrong");

  a_read_quiet: assert property (
    dp_valid_q && !dp_write_q && (st_q != KWDT_ACTIVE) |=> st_q == $past(st_q)
  ) else $error("read changed state");

  a_timeout_dead: assert property (
    (st_q == KWDT_TIMEOUT) |=> (st_q == KWDT_TIMEOUT) && !rd_ctrl2[`KWDT_C2_ARM]
      && !watchdog_irq && !wd_nmi && !wd_reset_req
  ) else $error("timeout state not dead");

  a_pre_guard: assert property (
    (st_q == KWDT_PRE) && key_wr && !k_first && !k_second
      |=> (mode_q == $past(mode_q)) && (st_q == KWDT_PRE)
  ) else $error("unkeyed write took effect");

  a_count_tick: assert property (
    tick && !expire && !key_wr |=> main_q == $past(main_q) - 16'h0001
  ) else $error("main counter missed tick");

  c_arm: cover property (go_pre ##[1:20] go_arm);
  c_service: cover property (svc);
  c_expire: cover property (expire);
  c_bad_key: cover property (bad_key);
endmodule
`default_nettype wire

// ==== kwdt_cpu_model.sv ====
// model of the cpu interrupt and reset logic that receives watchdog events
`timescale 1ns/100ps
`default_nettype none
module kwdt_cpu_model (
  input wire logic hclk,
  input wire logic watchdog_irq,
  input wire logic wd_nmi,
  input wire logic wd_reset_req,
  output logic [7:0] n_irq,
  output logic [7:0] n_nmi,
  output logic [7:0] n_rst
);
  // tallies start from zero and never clear, the bench compares deltas
  logic [7:0] irq_tally = 8'h00;
  logic [7:0] nmi_tally = 8'h00;
  logic [7:0] rst_tally = 8'h00;
  // count each one-cycle event pulse at the edge that sees it
  always @(posedge hclk) begin
    irq_tally <= irq_tally + 8'(watchdog_irq === 1'b1);
    nmi_tally <= nmi_tally + 8'(wd_nmi === 1'b1);
    rst_tally <= rst_tally + 8'(wd_reset_req === 1'b1);
  end
  // tallies out to the bench
  assign n_irq = irq_tally;
  assign n_nmi = nmi_tally;
  assign n_rst = rst_tally;
endmodule
`default_nettype wire

// ==== keyed_watchdog_timer_tb.sv ====
// self-checking bench for the keyed watchdog over ahb-lite
`timescale 1ns/100ps
`default_nettype none
`include "kwdt_consts.svh"
module keyed_watchdog_timer_tb;
  import kwdt_pkg::*;
  logic hclk, hresetn, hsel, hwrite;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, rd, hrdata;
  logic hreadyout, hresp, irq, nmi, rstq;
  kwdt_state_t state;
  logic [7:0] n_irq, n_nmi, n_rst, ci, cn, cr;
  int failures, tests_run, cyc;
  kwdt_top kwdt_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .watchdog_irq(irq),
    .wd_nmi(nmi), .wd_reset_req(rstq), .wd_state(state));
  kwdt_cpu_model kwdt_cpu_model_inst (.hclk(hclk), .watchdog_irq(irq), .wd_nmi(nmi),
    .wd_reset_req(rstq), .n_irq(n_irq), .n_nmi(n_nmi), .n_rst(n_rst));
  task automatic wrap_up;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one single ahb transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {14'h0, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d);
  endtask
  task automatic rdc(input string nm, input logic [15:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    check(nm, rd, exp);
    check("hresp", 32'(hresp), 32'h0);
  endtask
  task automatic st(input kwdt_state_t exp);
    @(negedge hclk);
    check("state", 32'(state), 32'(exp));
  endtask
  // negedges from the arming write until the timeout state shows
  task automatic run_out(input int lo, input int hi);
    cyc = 0;
    while (state !== KWDT_TIMEOUT && cyc < 200) begin
      @(negedge hclk);
      cyc++;
    end
    check("expiry", 32'(cyc >= lo && cyc <= hi), 32'h1);
  endtask
  task automatic snap;
    ci = n_irq;
    cn = n_nmi;
    cr = n_rst;
  endtask
  // pulse deltas since the last snapshot must match the route
  task automatic ev(input logic [1:0] r);
    repeat (3) @(negedge hclk);
    check("irq", 32'(n_irq - ci), 32'(r == 2'h0));
    check("nmi", 32'(n_nmi - cn), 32'(r == 2'h1));
    check("rst", 32'(n_rst - cr), 32'(r == 2'h2));
  endtask
  task automatic arm(input logic [31:0] period_value, input logic [31:0] c1, input logic m);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    wr(`KWDT_IDX_PERIOD, period_value);
    wr(`KWDT_IDX_CTRL1, c1);
    wr(`KWDT_IDX_CTRL2, 32'h05C6);
    snap();
    wr(`KWDT_IDX_CTRL2, {19'h0, m, 12'hA7E} | 32'h4000);
  endtask
  // free-running bench clock
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // hang guard
  initial begin
    #400000;
    failures++;
    wrap_up();
  end
  // main sequence
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    failures = 0;
    tests_run = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rdc("count", `KWDT_IDX_COUNT, 32'hFFFF);
    repeat (20) @(posedge hclk);
    rdc("count", `KWDT_IDX_COUNT, 32'hFFFF);
    rdc("period", `KWDT_IDX_PERIOD, 32'hFFFF);
    rdc("ctrl1", `KWDT_IDX_CTRL1, 32'h03CF);
    rdc("ctrl2", `KWDT_IDX_CTRL2, 32'h1000);
    rdc("unmapped", 16'h4004, 32'h0);
    wr(`KWDT_IDX_PERIOD, 32'h0003);
    rdc("period", `KWDT_IDX_PERIOD, 32'h0003);
    wr(`KWDT_IDX_CTRL1, 32'h1002);
    rdc("ctrl1", `KWDT_IDX_CTRL1, 32'h13C2);
    wr(`KWDT_IDX_CTRL2, 32'h05C6);
    st(KWDT_PRE);
    wr(`KWDT_IDX_CTRL2, 32'h1123);
    rdc("ctrl2", `KWDT_IDX_CTRL2, 32'h0);
    snap();
    wr(`KWDT_IDX_CTRL2, 32'h4A7E);
    run_out(8, 16);
    ev(2'h1);
    rdc("ctrl2", `KWDT_IDX_CTRL2, 32'h8000);
    snap();
    wr(`KWDT_IDX_CTRL2, 32'h05C6);
    wr(`KWDT_IDX_CTRL2, 32'h4A7E);
    st(KWDT_TIMEOUT);
    ev(2'h3);
    for (int r = 0; r < 4; r++) begin
      arm(32'h0100, 32'({r[1:0], 12'h00F}), r[0]);
      rdc("mode", `KWDT_IDX_CTRL2, 32'h4000 | 32'(r[0]) << 12);
      wr(`KWDT_IDX_PERIOD, 32'h0005);
      rdc("lock", `KWDT_IDX_PERIOD, 32'h0100);
      repeat (20) @(posedge hclk);
      wr(`KWDT_IDX_CTRL2, 32'h05C6);
      st(KWDT_ACTIVE);
      wr(`KWDT_IDX_CTRL2, 32'h0A7E);
      rdc("reload", `KWDT_IDX_COUNT, 32'h0100);
      snap();
      wr(`KWDT_IDX_CTRL2, r[0] ? 32'h0123 : 32'h0A7E);
      st(KWDT_TIMEOUT);
      ev(r[1:0]);
    end
    // divide 0: table preset 1 gives two clocks a tick, direct gives one
    arm(32'h0003, 32'h3000, 1'b1);
    run_out(8, 8);
    ev(2'h3);
    arm(32'h0003, 32'h3000, 1'b0);
    run_out(5, 5);
    wrap_up();
  end
endmodule
`default_nettype wire
